// ---- core/lhr_top.sv ----
`default_nettype none
`include "lhr_cfg.svh"

module lhr_top #(
    parameter int RST_HOLD_CYC = `LHR_RST_HOLD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic cs_n_i,
    input wire logic sdata_i,
    input wire logic register_select_i,
    input wire logic ext_clk_conn_i,
    input wire logic [3:0] disp_pos_i,
    input wire logic [2:0] disp_row_i,
    output logic [4:0] disp_dots_o,
    output logic [59:0] icon_o,
    output lhr_pkg::lhr_target_t target_o,
    output logic [7:0] pointer_o,
    output logic step_inc_o,
    output logic busy_o,
    output logic fifo_full_o,
    output logic device_reset_o,
    output logic clk_src_ext_o
);
    import lhr_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] mem_limit(input lhr_target_t tgt);
        case (tgt)
            TGT_CHAR: mem_limit = 8'(`LHR_CHAR_DEPTH);
            TGT_GLYPH: mem_limit = 8'(`LHR_GLYPH_DEPTH);
            TGT_ICON: mem_limit = 8'(`LHR_ICON_WORDS);
            default: mem_limit = 8'(`LHR_CHAR_DEPTH);
        endcase
    endfunction

    // wraps at both ends of the selected memory
    function automatic logic [7:0] ptr_step(input logic [7:0] ptr, input logic inc,
                                            input logic [7:0] lim);
        if (inc) begin
            ptr_step = (ptr >= lim - 8'h01) ? 8'h00 : ptr + 8'h01;
        end else begin
            ptr_step = (ptr == 8'h00) ? lim - 8'h01 : ptr - 8'h01;
        end
    endfunction

    // seven rows per user pattern, row 0 first
    function automatic logic [7:0] glyph_index(input logic [4:0] code, input logic [2:0] row);
        glyph_index = {code, 3'h0} - {3'h0, code} + {5'h00, row};
    endfunction

    // stand-in pattern: real font contents are a mask choice, not logic
    function automatic logic [4:0] fixed_glyph_table(input lhr_byte_t code,
                                                     input logic [2:0] row);
        fixed_glyph_table = code[4:0] ^ {code[7:5], 2'h0} ^ {2'h0, row};
    endfunction

    // ----------------------------------------------------------------
    // link domain: serial shift-in
    // ----------------------------------------------------------------
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [`LHR_WORD_W-1:0] link_word;
    logic link_tog;

    // chip select high forces the bit count back to a byte boundary
    always_ff @(posedge link_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt <= 3'h0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    always_ff @(posedge link_clk_i) begin
        shift <= {shift[5:0], sdata_i};
    end

    // msb first; select is taken with the last bit
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_word <= '0;
            link_tog <= 1'b0;
        end else if (!cs_n_i && bit_cnt == 3'h7) begin
            link_word <= {register_select_i, shift, sdata_i};
            link_tog <= ~link_tog;
        end
    end

    // ----------------------------------------------------------------
    // crossing into the system clock
    // ----------------------------------------------------------------
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic tog_seen;
    logic pending;
    logic [`LHR_WORD_W-1:0] pend_word;
    logic fifo_in_ready;

    // word is stable for a whole byte time, far beyond the sync delay
    wire tog_event = (tog_s2 == tog_s3) && (tog_s3 != tog_seen) && !pending;
    wire fifo_push = pending && fifo_in_ready;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // a full fifo holds the byte here; the next one waits behind it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tog_seen <= 1'b0;
            pending <= 1'b0;
            pend_word <= '0;
        end else if (tog_event) begin
            tog_seen <= tog_s3;
            pending <= 1'b1;
            pend_word <= link_word;
        end else if (fifo_push) begin
            pending <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // byte fifo
    // ----------------------------------------------------------------
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`LHR_WORD_W-1:0] fifo_out_data;

    lhr_fifo #(
        .WIDTH(`LHR_WORD_W),
        .DEPTH(`LHR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pending),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pend_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ----------------------------------------------------------------
    // command engine
    // ----------------------------------------------------------------
    lhr_state_t state;
    lhr_state_t next_state;
    lhr_byte_t instruction_holding_register;
    lhr_byte_t data_staging_register;
    logic [7:0] memory_pointer_counter;
    lhr_target_t target;
    logic step_inc;
    logic [3:0] clr_idx;

    lhr_byte_t character_code_memory [0:`LHR_CHAR_DEPTH-1];
    logic [`LHR_DOT_W-1:0] user_glyph_memory [0:`LHR_GLYPH_DEPTH-1];
    logic [`LHR_DOT_W-1:0] icon_pattern_memory [0:`LHR_ICON_WORDS-1];

    wire fifo_pop = fifo_out_valid && fifo_out_ready;
    wire pop_is_data = fifo_out_data[`LHR_SEL_POS];
    wire [7:0] lim = mem_limit(target);
    wire [7:0] ptr_next = ptr_step(memory_pointer_counter, step_inc, lim);
    wire clr_last = (clr_idx == 4'(`LHR_CHAR_DEPTH - 1));

    wire op_clear = instruction_holding_register == `LHR_OP_CLEAR;
    wire op_home = instruction_holding_register == `LHR_OP_HOME;
    wire op_mode = (instruction_holding_register & `LHR_OP_MODE_MASK) == `LHR_OP_MODE;
    wire op_icon = (instruction_holding_register & `LHR_OP_ICON_MASK) == `LHR_OP_ICON;
    wire op_glyph = (instruction_holding_register & `LHR_OP_GLYPH_MASK) == `LHR_OP_GLYPH;
    wire op_char = (instruction_holding_register & `LHR_OP_CHAR_MASK) == `LHR_OP_CHAR;
    wire [3:0] addr_lo = instruction_holding_register[3:0];
    wire icon_ok = addr_lo < 4'(`LHR_ICON_WORDS);
    wire char_ok = addr_lo < 4'(`LHR_CHAR_DEPTH);
    wire wr_data = (state == ST_DATA);

    assign fifo_out_ready = (state == ST_IDLE);

    always_comb begin
        case (state)
            ST_IDLE: next_state = !fifo_pop ? ST_IDLE : (pop_is_data ? ST_DATA : ST_INSTR);
            ST_INSTR: next_state = op_clear ? ST_CLEAR : ST_IDLE;
            ST_DATA: next_state = ST_IDLE;
            ST_CLEAR: next_state = clr_last ? ST_IDLE : ST_CLEAR;
            default: next_state = ST_IDLE;
        endcase
    end

    // select low lands in the instruction register, high in staging
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            instruction_holding_register <= 8'h00;
            data_staging_register <= 8'h00;
        end else begin
            state <= next_state;
            if (fifo_pop && !pop_is_data) begin
                instruction_holding_register <= fifo_out_data[7:0];
            end
            if (fifo_pop && pop_is_data) begin
                data_staging_register <= fifo_out_data[7:0];
            end
        end
    end

    // address codes load the pointer and pick the memory
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            memory_pointer_counter <= 8'h00;
            target <= TGT_CHAR;
            step_inc <= 1'b1;
        end else if (state == ST_INSTR) begin
            if (op_home) begin
                memory_pointer_counter <= 8'h00;
            end else if (op_mode) begin
                step_inc <= instruction_holding_register[`LHR_MODE_INC_POS];
            end else if (op_icon && icon_ok) begin
                memory_pointer_counter <= {4'h0, addr_lo};
                target <= TGT_ICON;
            end else if (op_glyph) begin
                memory_pointer_counter <= glyph_index(instruction_holding_register[4:0], 3'h0);
                target <= TGT_GLYPH;
            end else if (op_char && char_ok) begin
                memory_pointer_counter <= {4'h0, addr_lo};
                target <= TGT_CHAR;
            end
        end else if (wr_data) begin
            memory_pointer_counter <= ptr_next;
        end else if (state == ST_CLEAR && clr_last) begin
            memory_pointer_counter <= 8'h00;
            target <= TGT_CHAR;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || state != ST_CLEAR) begin
            clr_idx <= 4'h0;
        end else begin
            clr_idx <= clr_idx + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // display memories
    // ----------------------------------------------------------------
    // staged byte goes out with no further host action
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `LHR_CHAR_DEPTH; i++) begin
                character_code_memory[i] <= `LHR_BLANK_CODE;
            end
        end else if (state == ST_CLEAR) begin
            character_code_memory[clr_idx] <= `LHR_BLANK_CODE;
        end else if (wr_data && target == TGT_CHAR) begin
            character_code_memory[memory_pointer_counter[3:0]] <= data_staging_register;
        end
    end

    // large and never cleared: contents are undefined until written
    always_ff @(posedge sys_clk_i) begin
        if (wr_data && target == TGT_GLYPH) begin
            user_glyph_memory[memory_pointer_counter] <= data_staging_register[4:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `LHR_ICON_WORDS; i++) begin
                icon_pattern_memory[i] <= '0;
            end
        end else if (wr_data && target == TGT_ICON) begin
            icon_pattern_memory[memory_pointer_counter[3:0]] <= data_staging_register[4:0];
        end
    end

    // ----------------------------------------------------------------
    // pattern lookup for the display side
    // ----------------------------------------------------------------
    logic [`LHR_ICON_BITS-1:0] icon_flat;

    wire [3:0] pos_safe = (disp_pos_i < 4'(`LHR_CHAR_DEPTH)) ? disp_pos_i : 4'h0;
    wire [2:0] row_safe = (disp_row_i < 3'(`LHR_GLYPH_ROWS)) ? disp_row_i : 3'h0;
    wire lhr_byte_t disp_code = character_code_memory[pos_safe];
    wire from_user = disp_code < `LHR_FIXED_FIRST;
    wire [4:0] user_dots = user_glyph_memory[glyph_index(disp_code[4:0], row_safe)];
    wire [4:0] fixed_dots = fixed_glyph_table(disp_code, row_safe);
    wire [4:0] dots = from_user ? user_dots : fixed_dots;

    always_comb begin
        for (int i = 0; i < `LHR_ICON_WORDS; i++) begin
            icon_flat[i*`LHR_DOT_W +: `LHR_DOT_W] = icon_pattern_memory[i];
        end
    end

    // ----------------------------------------------------------------
    // long reset filter and clock source
    // ----------------------------------------------------------------
    logic [15:0] low_cnt;
    logic conn_s1;
    logic conn_s2;
    logic conn_s3;

    wire low_done = (low_cnt >= 16'(RST_HOLD_CYC));

    // only an unbroken low of the full hold counts as a device reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_n_i) begin
            low_cnt <= 16'h0000;
        end else if (!low_done) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        conn_s1 <= ext_clk_conn_i;
        conn_s2 <= conn_s1;
        conn_s3 <= conn_s2;
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            disp_dots_o <= 5'h00;
            icon_o <= '0;
            target_o <= TGT_CHAR;
            pointer_o <= 8'h00;
            step_inc_o <= 1'b1;
            busy_o <= 1'b0;
            fifo_full_o <= 1'b0;
            device_reset_o <= low_done;
            if (conn_s2 == conn_s3) begin
                clk_src_ext_o <= conn_s3;
            end
        end else begin
            disp_dots_o <= dots;
            icon_o <= icon_flat;
            target_o <= target;
            pointer_o <= memory_pointer_counter;
            step_inc_o <= step_inc;
            busy_o <= (state != ST_IDLE) || fifo_out_valid;
            fifo_full_o <= !fifo_in_ready;
            device_reset_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- common/lhr_cfg.svh ----
`ifndef LHR_CFG_SVH
`define LHR_CFG_SVH

// ----------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------
`define LHR_CHAR_DEPTH 14
`define LHR_GLYPH_ROWS 7
`define LHR_GLYPH_DEPTH 224
`define LHR_ICON_WORDS 12
`define LHR_ICON_BITS 60
`define LHR_DOT_W 5
`define LHR_FIXED_FIRST 8'h20
`define LHR_BLANK_CODE 8'h20

// ----------------------------------------------------------------
// link word: register select above the byte
// ----------------------------------------------------------------
`define LHR_BYTE_W 8
`define LHR_WORD_W 9
`define LHR_SEL_POS 8
`define LHR_FIFO_DEPTH 8

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define LHR_OP_CLEAR 8'h01
`define LHR_OP_HOME 8'h02
`define LHR_OP_MODE_MASK 8'hFC
`define LHR_OP_MODE 8'h04
`define LHR_MODE_INC_POS 1
`define LHR_OP_ICON_MASK 8'hF0
`define LHR_OP_ICON 8'h30
`define LHR_OP_GLYPH_MASK 8'hE0
`define LHR_OP_GLYPH 8'h40
`define LHR_OP_CHAR_MASK 8'hF0
`define LHR_OP_CHAR 8'h80

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LHR_SYS_CLK_HZ 10000000
`define LHR_LINK_MAX_HZ 1000000
`define LHR_OSC_REF_HZ 145000
`define LHR_RST_HOLD_US 1200
`define LHR_RST_HOLD_CYC (`LHR_RST_HOLD_US * (`LHR_SYS_CLK_HZ / 1000000))

`endif

// ---- common/lhr_pkg.sv ----
`default_nettype none

package lhr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA = 2'b11,
        ST_CLEAR = 2'b10
    } lhr_state_t;

    typedef enum logic [1:0] {
        TGT_CHAR = 2'b00,
        TGT_GLYPH = 2'b01,
        TGT_ICON = 2'b10
    } lhr_target_t;

    typedef logic [7:0] lhr_byte_t;

endpackage

`default_nettype wire

// ---- core/lhr_fifo.sv ----
`default_nettype none

module lhr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

    assign in_ready_o = (count != (AW + 1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == last_ptr) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == last_ptr) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- test/lhr_top_chk.sv ----
`default_nettype none

module lhr_top_chk #(
    parameter int RST_HOLD_CYC = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire lhr_pkg::lhr_target_t target_o,
    input wire logic [7:0] pointer_o,
    input wire logic step_inc_o,
    input wire logic busy_o,
    input wire logic device_reset_o,
    input wire logic clk_src_ext_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import lhr_pkg::*;

    // outputs are unknown until the first reset edge has been seen
    bit armed;
    always_ff @(posedge sys_clk_i) begin
        armed <= armed || !rst_n_i;
    end

    // saturating, so a very long reset cannot wrap the count
    int low_cnt;
    always_ff @(posedge sys_clk_i) begin
        low_cnt <= rst_n_i ? 0 : (low_cnt < 1000 ? low_cnt + 1 : low_cnt);
    end

    sequence s_quiet;
        !busy_o [*4];
    endsequence

    a_reset_state: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> pointer_o == 8'h00 && step_inc_o && target_o == TGT_CHAR)
        else $error("state not cleared by reset");
    a_hold_early: assert property (@(posedge sys_clk_i)
        armed && low_cnt <= RST_HOLD_CYC |-> !device_reset_o)
        else $error("device reset before hold time");
    a_hold_late: assert property (@(posedge sys_clk_i)
        low_cnt > RST_HOLD_CYC |-> device_reset_o)
        else $error("device reset missing after hold time");
    a_char_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        target_o == TGT_CHAR |-> pointer_o < 8'h0E)
        else $error("character pointer out of range");
    a_icon_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        target_o == TGT_ICON |-> pointer_o < 8'h0C)
        else $error("icon pointer out of range");
    a_glyph_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        target_o == TGT_GLYPH |-> pointer_o < 8'hE0)
        else $error("glyph pointer out of range");
    a_target_legal: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        armed |-> target_o != 2'b11)
        else $error("no memory behind target");
    a_idle_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_quiet |-> $stable(pointer_o) && $stable(target_o) && $stable(step_inc_o))
        else $error("state moved while idle");
    a_src_latched: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> $stable(clk_src_ext_o))
        else $error("clock source changed outside reset");
endmodule

bind lhr_top lhr_top_chk #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .target_o(target_o),
    .pointer_o(pointer_o),
    .step_inc_o(step_inc_o),
    .busy_o(busy_o),
    .device_reset_o(device_reset_o),
    .clk_src_ext_o(clk_src_ext_o)
);

`default_nettype wire

// ---- test/lhr_host_model.sv ----
`default_nettype none

module lhr_host_model (
    output logic link_clk_o,
    output logic cs_n_o,
    output logic sdata_o,
    output logic register_select_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_clk_o = 1'b0;
        sdata_o = 1'b1;
        register_select_o = 1'b1;
        // a late deselect edge clears the bit count before the first frame
        #1 cs_n_o = 1'b1;
    end

    // one byte a frame, msb first; the shift clock stands still between frames
    task automatic send(input logic sel, input logic [7:0] b);
        int i;
        cs_n_o = 1'b0;
        register_select_o = sel;
        for (i = 7; i >= 0; i--) begin
            sdata_o = b[i];
            #7.5 link_clk_o = 1'b1;
            #7.5 link_clk_o = 1'b0;
        end
        #7.5 cs_n_o = 1'b1;
        // released lines never keep the last value
        sdata_o = ~b[0];
        register_select_o = ~sel;
    endtask
endmodule

`default_nettype wire

// ---- test/lhr_top_tb.sv ----
`default_nettype none

module lhr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lhr_pkg::*;

    localparam int HOLD = 20;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b1;
    logic ext_conn = 1'b1;
    logic [3:0] pos = 4'h0;
    logic [2:0] row = 3'h0;
    logic link_clk, cs_n, sdata, rsel;
    logic [4:0] dots;
    logic [59:0] icon;
    lhr_target_t tgt;
    logic [7:0] ptr;
    logic step_inc, busy, full, dev_rst, clk_ext;
    int error_cnt = 0;
    int cmp_count = 0;

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    lhr_top #(.RST_HOLD_CYC(HOLD)) DUT (
        .sys_clk_i(sys_clk),
        .rst_n_i(rst_n),
        .link_clk_i(link_clk),
        .cs_n_i(cs_n),
        .sdata_i(sdata),
        .register_select_i(rsel),
        .ext_clk_conn_i(ext_conn),
        .disp_pos_i(pos),
        .disp_row_i(row),
        .disp_dots_o(dots),
        .icon_o(icon),
        .target_o(tgt),
        .pointer_o(ptr),
        .step_inc_o(step_inc),
        .busy_o(busy),
        .fifo_full_o(full),
        .device_reset_o(dev_rst),
        .clk_src_ext_o(clk_ext)
    );

    lhr_host_model host (
        .link_clk_o(link_clk),
        .cs_n_o(cs_n),
        .sdata_o(sdata),
        .register_select_o(rsel)
    );

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [59:0] got, input logic [59:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // byte crosses the sync and fifo before the engine sees it
    task automatic put(input logic sel, input logic [7:0] b);
        int n;
        host.send(sel, b);
        repeat (12) @(negedge sys_clk);
        for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge sys_clk);
        if (n == 40) begin
            error_cnt++;
            $display("BAD t=%0t busy stuck", $time);
            results();
        end
    endtask

    task automatic look(input logic [3:0] p, input logic [2:0] r, input logic [4:0] exp);
        @(posedge sys_clk);
        pos <= p;
        row <= r;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(dots, exp, "dots");
    endtask

    task automatic do_reset(input int n, input logic strap);
        @(posedge sys_clk);
        ext_conn <= strap;
        rst_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(dev_rst, n > HOLD, "hold");
        chk(clk_ext, strap, "clock source");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk({ptr, tgt, step_inc, busy, full}, {8'h00, TGT_CHAR, 3'b100}, "reset");
    endtask

    task automatic t_char();
        put(1'b0, 8'h85);
        chk({tgt, ptr}, {TGT_CHAR, 8'h05}, "char addr");
        put(1'b1, 8'h41);
        chk(ptr, 8'h06, "step up");
        look(4'h5, 3'h3, 5'h0A);
        put(1'b0, 8'h8E);
        chk(ptr, 8'h06, "addr 14");
    endtask

    task automatic t_down();
        put(1'b0, 8'h04);
        chk(step_inc, 1'b0, "down");
        put(1'b0, 8'h80);
        put(1'b1, 8'h21);
        chk(ptr, 8'h0D, "wrap down");
        put(1'b0, 8'h06);
        chk(step_inc, 1'b1, "up");
    endtask

    task automatic t_glyph();
        put(1'b0, 8'h42);
        chk({tgt, ptr}, {TGT_GLYPH, 8'h0E}, "glyph addr");
        put(1'b1, 8'h15);
        chk(ptr, 8'h0F, "glyph step");
        put(1'b0, 8'h80);
        put(1'b1, 8'h02);
        look(4'h0, 3'h0, 5'h15);
        put(1'b0, 8'h5F);
        chk(ptr, 8'hD9, "last glyph");
    endtask

    task automatic t_icon();
        put(1'b0, 8'h3B);
        chk({tgt, ptr}, {TGT_ICON, 8'h0B}, "icon addr");
        put(1'b1, 8'h1F);
        chk({icon[59:55], ptr}, {5'h1F, 8'h00}, "last icon");
    endtask

    task automatic t_clear();
        put(1'b0, 8'h87);
        put(1'b0, 8'h02);
        chk(ptr, 8'h00, "home");
        put(1'b0, 8'h3B);
        put(1'b0, 8'h01);
        chk({tgt, ptr}, {TGT_CHAR, 8'h00}, "clear");
        look(4'hD, 3'h0, 5'h04);
        look(4'h0, 3'h0, 5'h04);
    endtask

    initial begin
        do_reset(6, 1'b1);
        t_char();
        t_down();
        t_glyph();
        t_icon();
        t_clear();
        put(1'b0, 8'h04);
        do_reset(HOLD + 6, 1'b0);
        results();
    end
endmodule

`default_nettype wire
